// ===== hdl/hsiec_cmd.sv
`timescale 1ns/1ns
// Operation
// - hub reset request sets function_reset_pending
// - reading set reset flag clears, enables, reports done
// - sleep change sets sleep_state_changed; read clears
// - sleep flag reads one while port suspended
// - writing zero while suspended triggers remote wake
// - attach change sets attach_state_changed; read clears
// - attach bit write connects/disconnects; read shows state
// - codes e0..e2 access functions one to three
// - status writes ignore read-only bits
// - status read clears both change flags and reset
// - sleep change or reset flag raises interrupt
// - code fd returns 12-bit id, low byte first
// - id holds part digit and silicon release
// - code fb writes vid lo/hi, pid lo/hi
// - code ff returns failed flag and code
// - failed flag refreshed on every packet
// - codes 0..2: none, pid encoding, pid unknown
// - codes 3..8: unexpected, crc, timeout, babble, eop
// - code 9 nak, code a stall
// - codes b..e: overflow, iso empty, stuffing, sync
// - code f toggle error, packet data discarded
module hsiec_cmd (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // microcontroller command port
  input wire logic cmd_stb,
  input wire logic [7:0] cmd_code,
  input wire logic wr_stb,
  input wire logic [7:0] wr_data,
  input wire logic rd_stb,
  output logic [7:0] rd_data_q,
  // hub controller / sie side, per embedded function
  input wire logic [2:0] func_reset_req,
  input wire logic [2:0] func_sleep,
  output logic [2:0] attach_q,
  output logic [2:0] wake_q,
  output logic [2:0] port_enable_q,
  output logic [2:0] reset_done_q,
  output logic [2:0] int_sleep_q,
  output logic [2:0] int_reset_q,
  output logic irq_q,
  // packet result from the sie
  input wire logic pkt_done,
  input wire logic [15:1] pkt_err_flags,
  output logic discard_q,
  // descriptor side read of vendor/product identity
  input wire logic [1:0] desc_addr,
  output logic [7:0] desc_data_q
);

  // lowest set condition wins; shared by the code and discard paths
  function automatic logic [3:0] err_encode(input logic [15:1] f);
    logic [3:0] c;
    c = hsiec_pkg::ERR_NONE;
    for (int k = 15; k >= 1; k--)
    begin
      if (f[k])
      begin
        c = 4'(k);
      end
    end
    return c;
  endfunction

  // true when a code addresses embedded function n
  function automatic logic stat_sel(input logic [7:0] c, input int n);
    return c == (hsiec_pkg::CMD_STAT_BASE + 8'(n));
  endfunction

  logic [7:0] cmd_q; // command in progress
  logic [2:0] idx_q; // data byte index within the command
  logic [2:0] idx_d; // saturating next index
  logic data_stb; // any data byte strobe
  logic last_failed_q; // last_packet_failed
  logic [3:0] reason_q; // failure_reason of latest error
  logic [3:0] new_code; // encoded result of this packet
  logic ident_wr; // byte write into identity store
  logic [7:0] rd_mux; // byte for the current read
  logic [7:0] id_byte; // part id byte for current index
  logic [7:0] err_byte; // last error byte
  logic [7:0] stat_byte [3]; // status byte per function
  logic [2:0] rd_hit; // status read per function
  logic [2:0] wr_hit; // status write per function
  logic [2:0] slpchg; // sleep_state_changed per function
  logic [2:0] rstpend; // function_reset_pending per function
  logic [2:0] attach; // attach flags gathered
  logic [2:0] wake; // wake pulses gathered
  logic [2:0] enab; // enable pulses gathered
  logic [2:0] done; // done pulses gathered

  assign data_stb = rd_stb | wr_stb;
  assign idx_d = (idx_q == 3'h4) ? idx_q : idx_q + 3'h1;

  // command latch; a new code restarts the byte count
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cmd_q <= hsiec_pkg::RST_BYTE;
      idx_q <= 3'h0;
    end
    else if (ce)
    begin
      if (cmd_stb)
      begin
        cmd_q <= cmd_code;
        idx_q <= 3'h0;
      end
      else if (data_stb)
      begin
        idx_q <= idx_d;
      end
    end
  end

  // per-function status logic
  genvar gi;
  generate
    for (gi = 0; gi < hsiec_pkg::NUM_FUNC; gi++)
    begin : g_func
      logic sleep_q; // sampled suspend state
      logic slpchg_q;
      logic attach_r;
      logic attchg_q;
      logic rst_q;
      logic wake_r;
      logic enab_r;
      logic done_r;
      logic sleep_flip; // suspend state differs from last sample
      logic attach_flip; // write changes the attach state
      logic wake_now; // zero written while suspended

      assign rd_hit[gi] = rd_stb && stat_sel(cmd_q, gi);
      assign wr_hit[gi] = wr_stb && stat_sel(cmd_q, gi);
      assign sleep_flip = func_sleep[gi] != sleep_q;
      assign attach_flip = wr_hit[gi]
        && (wr_data[hsiec_pkg::ST_ATTACH] != attach_r);
      // only bit 0 and a zero on bit 2 matter
      assign wake_now = wr_hit[gi] && sleep_q
        && !wr_data[hsiec_pkg::ST_SLEEP];

      // flags: a set arriving with the clearing read wins
      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
        begin
          sleep_q <= 1'b0;
          slpchg_q <= 1'b0;
          attach_r <= 1'b0;
          attchg_q <= 1'b0;
          rst_q <= 1'b0;
        end
        else if (ce)
        begin
          sleep_q <= func_sleep[gi];
          if (sleep_flip)
            slpchg_q <= 1'b1;
          else if (rd_hit[gi])
            slpchg_q <= 1'b0;
          if (wr_hit[gi])
            attach_r <= wr_data[hsiec_pkg::ST_ATTACH];
          if (attach_flip)
            attchg_q <= 1'b1;
          else if (rd_hit[gi])
            attchg_q <= 1'b0;
          if (func_reset_req[gi])
            rst_q <= 1'b1;
          else if (rd_hit[gi])
            rst_q <= 1'b0;
        end
      end

      // one-cycle pulses toward the hub controller
      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
        begin
          wake_r <= 1'b0;
          enab_r <= 1'b0;
          done_r <= 1'b0;
        end
        else if (ce)
        begin
          wake_r <= wake_now;
          enab_r <= rd_hit[gi] && rst_q;
          done_r <= rd_hit[gi] && rst_q;
        end
      end

      assign stat_byte[gi] = {3'h0, rst_q, slpchg_q, sleep_q,
        attchg_q, attach_r};
      assign slpchg[gi] = slpchg_q;
      assign rstpend[gi] = rst_q;
      assign attach[gi] = attach_r;
      assign wake[gi] = wake_r;
      assign enab[gi] = enab_r;
      assign done[gi] = done_r;
    end
  endgenerate

  assign attach_q = attach;
  assign wake_q = wake;
  assign port_enable_q = enab;
  assign reset_done_q = done;
  assign int_sleep_q = slpchg;
  assign int_reset_q = rstpend;

  // interrupt level follows the pending flags, one cycle behind
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      irq_q <= 1'b0;
    else if (ce)
      irq_q <= |(slpchg | rstpend);
  end

  // packet result; a code is only kept when the packet failed
  assign new_code = err_encode(pkt_err_flags);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      last_failed_q <= 1'b0;
      reason_q <= hsiec_pkg::RST_NIBBLE;
      discard_q <= 1'b0;
    end
    else if (ce)
    begin
      if (pkt_done)
        last_failed_q <= new_code != hsiec_pkg::ERR_NONE;
      if (pkt_done && new_code != hsiec_pkg::ERR_NONE)
        reason_q <= new_code;
      discard_q <= pkt_done
        && new_code == hsiec_pkg::ERR_TOGGLE;
    end
  end

  // identity store; bytes beyond the fourth are dropped
  assign ident_wr = wr_stb && cmd_q == hsiec_pkg::CMD_SET_IDENT
    && idx_q < 3'(hsiec_pkg::IDENT_BYTES);

  hsiec_idmem u_idmem (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .wr_en(ident_wr),
    .wr_addr(idx_q[1:0]),
    .wr_data(wr_data),
    .rd_addr(desc_addr),
    .rd_data_q(desc_data_q)
  );

  // read byte selection
  assign id_byte = (idx_q == 3'h0) ? hsiec_pkg::SILICON_REL_DEF
    : (idx_q == 3'h1) ? {hsiec_pkg::ID_PAD, hsiec_pkg::PART_DIGIT_DEF}
    : hsiec_pkg::RST_BYTE;
  assign err_byte = {hsiec_pkg::LE_RSVD, last_failed_q,
    reason_q};

  always_comb
  begin
    rd_mux = hsiec_pkg::RST_BYTE;
    // status is one byte; further reads return zero
    if (idx_q == 3'h0)
    begin
      for (int n = 0; n < hsiec_pkg::NUM_FUNC; n++)
      begin
        if (stat_sel(cmd_q, n))
          rd_mux = stat_byte[n];
      end
      if (cmd_q == hsiec_pkg::CMD_LAST_ERR)
        rd_mux = err_byte;
    end
    if (cmd_q == hsiec_pkg::CMD_PART_ID)
      rd_mux = id_byte;
  end

  // read data register, updated on each read strobe
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rd_data_q <= hsiec_pkg::RST_BYTE;
    else if (ce && rd_stb)
      rd_data_q <= rd_mux;
  end

endmodule // hsiec_cmd

// ===== hdl/hsiec_pkg.sv
package hsiec_pkg;

  // command codes seen on the microcontroller command port
  localparam logic [7:0] CMD_STAT_BASE = 8'he0; // embedded function 1
  localparam logic [7:0] CMD_STAT_LAST = 8'he2; // embedded function 3
  localparam logic [7:0] CMD_SET_IDENT = 8'hfb; // vendor/product id write
  localparam logic [7:0] CMD_PART_ID = 8'hfd; // part identification read
  localparam logic [7:0] CMD_LAST_ERR = 8'hff; // last error read

  // number of embedded functions
  localparam int unsigned NUM_FUNC = 3;

  // embedded_function_status field positions
  localparam int unsigned ST_ATTACH = 0; // attach state, r/w
  localparam int unsigned ST_ATTACH_CHG = 1; // attach_state_changed, r
  localparam int unsigned ST_SLEEP = 2; // sleep state, r/w
  localparam int unsigned ST_SLEEP_CHG = 3; // sleep_state_changed, r
  localparam int unsigned ST_FUNC_RST = 4; // function_reset_pending, r

  // part_identification layout and byte counts
  localparam int unsigned PART_ID_BYTES = 2;
  localparam int unsigned IDENT_BYTES = 4;
  localparam logic [3:0] ID_PAD = 4'h0; // upper nibble of second byte

  // last_transfer_error layout
  localparam int unsigned LE_FAILED = 4; // last_packet_failed position
  localparam logic [2:0] LE_RSVD = 3'h0; // bits 7..5

  // failure_reason encodings
  localparam logic [3:0] ERR_NONE = 4'h0;
  localparam logic [3:0] ERR_PID_ENC = 4'h1;
  localparam logic [3:0] ERR_PID_UNK = 4'h2;
  localparam logic [3:0] ERR_UNEXP_PKT = 4'h3;
  localparam logic [3:0] ERR_TOKEN_CRC = 4'h4;
  localparam logic [3:0] ERR_DATA_CRC = 4'h5;
  localparam logic [3:0] ERR_TIMEOUT = 4'h6;
  localparam logic [3:0] ERR_BABBLE = 4'h7;
  localparam logic [3:0] ERR_UNEXP_EOP = 4'h8;
  localparam logic [3:0] ERR_NAK = 4'h9;
  localparam logic [3:0] ERR_STALL = 4'ha;
  localparam logic [3:0] ERR_OVERFLOW = 4'hb;
  localparam logic [3:0] ERR_ISO_EMPTY = 4'hc;
  localparam logic [3:0] ERR_BITSTUFF = 4'hd;
  localparam logic [3:0] ERR_SYNC = 4'he;
  localparam logic [3:0] ERR_TOGGLE = 4'hf;

  // reset values (all flags clear, ports detached)
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_NIBBLE = 4'h0;

  // identity values; arbitrary, not those of any real part
  localparam logic [3:0] PART_DIGIT_DEF = 4'h3; // arbitrary value
  localparam logic [7:0] SILICON_REL_DEF = 8'h2a; // arbitrary value
  localparam logic [7:0] VID_LO_DEF = 8'h5a; // arbitrary value
  localparam logic [7:0] VID_HI_DEF = 8'ha5; // arbitrary value
  localparam logic [7:0] PID_LO_DEF = 8'h3c; // arbitrary value
  localparam logic [7:0] PID_HI_DEF = 8'hc3; // arbitrary value

endpackage

// ===== hdl/hsiec_idmem.sv
`timescale 1ns/1ns
// four-byte vendor/product identity store, registered read port
module hsiec_idmem (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [1:0] rd_addr,
  output logic [7:0] rd_data_q
);

  logic [7:0] mem_q [4]; // vid lo, vid hi, pid lo, pid hi

  // storage; reset restores the built-in identity
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mem_q[0] <= hsiec_pkg::VID_LO_DEF;
      mem_q[1] <= hsiec_pkg::VID_HI_DEF;
      mem_q[2] <= hsiec_pkg::PID_LO_DEF;
      mem_q[3] <= hsiec_pkg::PID_HI_DEF;
    end
    else if (ce && wr_en)
    begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // read data registered so the descriptor side sees a flop
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_data_q <= hsiec_pkg::RST_BYTE;
    end
    else if (ce)
    begin
      rd_data_q <= mem_q[rd_addr];
    end
  end

endmodule // hsiec_idmem

// ===== verif/hsiec_cmd_assertions.sv
`timescale 1ns/1ns
// port-level checks on the command block, one clock domain
module hsiec_chk (
  input logic clk,
  input logic rstn,
  input logic ce,
  input logic cmd_stb,
  input logic [7:0] cmd_code,
  input logic wr_stb,
  input logic rd_stb,
  input logic [7:0] rd_data_q,
  input logic [2:0] func_reset_req,
  input logic [2:0] func_sleep,
  input logic [2:0] attach_q,
  input logic [2:0] wake_q,
  input logic [2:0] port_enable_q,
  input logic [2:0] reset_done_q,
  input logic [2:0] int_sleep_q,
  input logic [2:0] int_reset_q,
  input logic irq_q,
  input logic pkt_done,
  input logic [15:1] pkt_err_flags,
  input logic discard_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_IRQ_FOLLOW: assert property (
    irq_q == $past(|(int_sleep_q | int_reset_q))
  ) else $error("irq does not follow the flags");
  AST_PART_ID_LOW: assert property (
    (ce && cmd_stb && cmd_code == hsiec_pkg::CMD_PART_ID) ##1
    (ce && rd_stb && !cmd_stb) |=> rd_data_q == hsiec_pkg::SILICON_REL_DEF
  ) else $error("first id byte wrong");
  AST_WAKE_CAUSE: assert property (
    |wake_q |-> $past(ce && wr_stb)
  ) else $error("wake without a write");
  AST_ENA_DONE: assert property (
    port_enable_q == reset_done_q
  ) else $error("enable and done differ");
  AST_ENA_CAUSE: assert property (
    |port_enable_q |->
    $past(ce && rd_stb) && (($past(int_reset_q) & port_enable_q) != 3'h0)
  ) else $error("enable without reset flag read");
  AST_DISCARD: assert property (
    ce && pkt_done && pkt_err_flags == 15'h4000 |=> discard_q
  ) else $error("toggle error not discarded");
  AST_NO_DISCARD: assert property (
    ce && pkt_done && !pkt_err_flags[15] |=> !discard_q
  ) else $error("discard without toggle error");
  AST_ATTACH_WRITE: assert property (
    !$stable(attach_q) |-> $past(ce && wr_stb)
  ) else $error("attach moved without a write");
  AST_SLEEP_SET: assert property (
    ce && $rose(func_sleep[2]) |-> ##[1:3] int_sleep_q[2]
  ) else $error("sleep change not flagged");
  AST_RESET_SET: assert property (
    ce && func_reset_req[0] |-> ##[1:2] int_reset_q[0]
  ) else $error("reset request not flagged");
endmodule // hsiec_chk

bind hsiec_cmd hsiec_chk u_chk (
  .clk(clk), .rstn(rstn), .ce(ce), .cmd_stb(cmd_stb),
  .cmd_code(cmd_code), .wr_stb(wr_stb), .rd_stb(rd_stb),
  .rd_data_q(rd_data_q), .func_reset_req(func_reset_req),
  .func_sleep(func_sleep), .attach_q(attach_q), .wake_q(wake_q),
  .port_enable_q(port_enable_q), .reset_done_q(reset_done_q),
  .int_sleep_q(int_sleep_q), .int_reset_q(int_reset_q), .irq_q(irq_q),
  .pkt_done(pkt_done), .pkt_err_flags(pkt_err_flags),
  .discard_q(discard_q)
);

// ===== verif/hsiec_mcu_model.sv
`timescale 1ns/1ns
// microcontroller side: strobes change only at the falling edge
module hsiec_mcu_model (
  input logic clk,
  input logic [7:0] rd_data_q,
  output logic ce,
  output logic cmd_stb,
  output logic [7:0] cmd_code,
  output logic wr_stb,
  output logic [7:0] wr_data,
  output logic rd_stb
);
  initial
  begin
    ce = 1'b1; // running; the bench drops it to check the freeze
    cmd_stb = 1'b0;
    cmd_code = 8'h00;
    wr_stb = 1'b0;
    wr_data = 8'h00;
    rd_stb = 1'b0;
  end
  // clock enable, changed only at the falling edge like the strobes
  task automatic set_ce(input logic v);
    ce = v;
  endtask
  // command strobe; a data strobe may follow at once
  task automatic send_cmd(input logic [7:0] c);
    cmd_code = c;
    cmd_stb = 1'b1;
    @(negedge clk);
    cmd_stb = 1'b0;
    cmd_code = ~c; // released code must not look valid
  endtask
  // one byte, then a dead cycle so two strobes never merge
  task automatic send_byte(input logic [7:0] b);
    wr_data = b;
    wr_stb = 1'b1;
    @(negedge clk);
    wr_stb = 1'b0;
    wr_data = ~b;
    @(negedge clk);
  endtask
  // read data is settled one edge after the strobe
  task automatic get_byte(output logic [7:0] b);
    rd_stb = 1'b1;
    @(negedge clk);
    b = rd_data_q;
    rd_stb = 1'b0;
    @(negedge clk);
  endtask
endmodule // hsiec_mcu_model

// ===== verif/hsiec_cmd_test.sv
`timescale 1ns/1ns
// directed bench for the hub command block
module hsiec_cmd_test;
  logic clk = 1'b0;
  logic rstn, ce, cmd_stb, wr_stb, rd_stb, pkt_done, irq_q, discard_q;
  logic [7:0] cmd_code, wr_data, rd_data_q, desc_data_q, v;
  logic [2:0] func_reset_req, func_sleep, attach_q, wake_q, port_enable_q;
  logic [2:0] reset_done_q, int_sleep_q, int_reset_q;
  logic [15:1] pkt_err_flags;
  logic [1:0] desc_addr;
  logic [2:0] wake_seen = 3'h0; // sticky copies of one-cycle pulses
  logic [2:0] ena_seen = 3'h0;
  logic disc_seen = 1'b0;
  int err_count = 0;
  int compares = 0;
  int cyc = 0;

  always #4 clk = ~clk; // 125 MHz

  hsiec_cmd DUT (
    .clk(clk), .rstn(rstn), .ce(ce), .cmd_stb(cmd_stb),
    .cmd_code(cmd_code), .wr_stb(wr_stb), .wr_data(wr_data),
    .rd_stb(rd_stb), .rd_data_q(rd_data_q),
    .func_reset_req(func_reset_req), .func_sleep(func_sleep),
    .attach_q(attach_q), .wake_q(wake_q), .port_enable_q(port_enable_q),
    .reset_done_q(reset_done_q), .int_sleep_q(int_sleep_q),
    .int_reset_q(int_reset_q), .irq_q(irq_q), .pkt_done(pkt_done),
    .pkt_err_flags(pkt_err_flags), .discard_q(discard_q),
    .desc_addr(desc_addr), .desc_data_q(desc_data_q)
  );
  hsiec_mcu_model u_mcu (
    .clk(clk), .rd_data_q(rd_data_q), .ce(ce), .cmd_stb(cmd_stb),
    .cmd_code(cmd_code), .wr_stb(wr_stb), .wr_data(wr_data),
    .rd_stb(rd_stb)
  );

  task automatic tally_and_finish();
    if (err_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one-byte command read and compare
  task automatic rd_chk(input string nm, input logic [7:0] c,
                        input logic [7:0] e);
    u_mcu.send_cmd(c);
    u_mcu.get_byte(v);
    chk(nm, e, v);
  endtask
  // packet result; flags scrambled once released
  task automatic pkt(input logic [15:1] f);
    pkt_err_flags = f;
    pkt_done = 1'b1;
    @(negedge clk);
    pkt_done = 1'b0;
    pkt_err_flags = ~f;
  endtask

  // latch pulses; hang guard well above the run length
  always @(posedge clk)
  begin
    wake_seen <= wake_seen | wake_q;
    ena_seen <= ena_seen | port_enable_q;
    disc_seen <= disc_seen | discard_q;
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_count++;
      tally_and_finish();
    end
  end

  initial
  begin
    rstn = 1'b0;
    func_reset_req = 3'h0;
    func_sleep = 3'h0;
    pkt_done = 1'b0;
    pkt_err_flags = 15'h0;
    desc_addr = 2'h0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      rd_chk("stat", hsiec_pkg::CMD_STAT_BASE + 8'(i), 8'h00);
    end
    rd_chk("err_rst", hsiec_pkg::CMD_LAST_ERR, 8'h00);
    // connect function 2, then read the change flag away
    u_mcu.send_cmd(8'he1);
    u_mcu.send_byte(8'h01);
    chk("attach", 8'h02, {5'h0, attach_q});
    rd_chk("stat_con", 8'he1, 8'h03);
    rd_chk("stat_con2", 8'he1, 8'h01);
    // junk in read-only bits, sleep bit zero while awake
    u_mcu.send_cmd(8'he1);
    u_mcu.send_byte(8'hfa);
    rd_chk("stat_dis", 8'he1, 8'h02);
    chk("no_wake", 8'h00, {5'h0, wake_seen});
    // suspend function 3, then wake it by a zero write
    func_sleep = 3'h4;
    repeat (3) @(negedge clk);
    chk("irq", 8'h01, {7'h0, irq_q});
    rd_chk("stat_slp", 8'he2, 8'h0c);
    u_mcu.send_cmd(8'he2);
    u_mcu.send_byte(8'hfe);
    chk("wake_one", 8'h00, {5'h0, wake_seen});
    u_mcu.send_cmd(8'he2);
    u_mcu.send_byte(8'h00);
    chk("wake", 8'h04, {5'h0, wake_seen});
    chk("irq_clr", 8'h00, {7'h0, irq_q});
    func_sleep = 3'h0;
    repeat (3) @(negedge clk);
    rd_chk("stat_res", 8'he2, 8'h08);
    // hub reset request on function 1
    func_reset_req = 3'h1;
    @(negedge clk);
    func_reset_req = 3'h0;
    @(negedge clk);
    rd_chk("stat_rst", 8'he0, 8'h10);
    chk("enable", 8'h01, {5'h0, ena_seen});
    rd_chk("stat_rst2", 8'he0, 8'h00);
    // freeze: events while ce is low must leave no trace
    u_mcu.set_ce(1'b0);
    func_reset_req = 3'h2;
    func_sleep = 3'h1;
    @(negedge clk);
    func_reset_req = 3'h0;
    func_sleep = 3'h0;
    @(negedge clk);
    u_mcu.set_ce(1'b1);
    rd_chk("frz_rst", 8'he1, 8'h00);
    rd_chk("frz_slp", 8'he0, 8'h00);
    // reset on function 3 while function 2 enters suspend
    func_reset_req = 3'h4;
    func_sleep = 3'h2;
    @(negedge clk);
    func_reset_req = 3'h0;
    rd_chk("stat_rst3", 8'he2, 8'h10);
    chk("enable3", 8'h05, {5'h0, ena_seen});
    rd_chk("stat_slp2", 8'he1, 8'h0c);
    func_sleep = 3'h0;
    repeat (2) @(negedge clk);
    rd_chk("stat_res2", 8'he1, 8'h08);
    // part id: low byte first, then past the end
    u_mcu.send_cmd(hsiec_pkg::CMD_PART_ID);
    u_mcu.get_byte(v);
    chk("id_lo", hsiec_pkg::SILICON_REL_DEF, v);
    u_mcu.get_byte(v);
    chk("id_hi", {4'h0, hsiec_pkg::PART_DIGIT_DEF}, v);
    u_mcu.get_byte(v);
    chk("id_past", 8'h00, v);
    // identity write, fifth byte must be dropped
    u_mcu.send_cmd(hsiec_pkg::CMD_SET_IDENT);
    for (int a = 0; a < 5; a++)
    begin
      u_mcu.send_byte(8'h11 * 8'(a + 1));
    end
    for (int a = 0; a < 4; a++)
    begin
      desc_addr = 2'(a);
      @(negedge clk);
      chk("ident", 8'h11 * 8'(a + 1), desc_data_q);
    end
    // every failure reason in turn
    for (int k = 1; k < 16; k++)
    begin
      pkt(15'h1 << (k - 1));
      rd_chk("err", hsiec_pkg::CMD_LAST_ERR, {4'h1, 4'(k)});
      chk("discard", {7'h0, k == 15}, {7'h0, disc_seen});
    end
    // codes 2 and 3 together: the lower code is reported
    pkt(15'h0006);
    rd_chk("err_pri", hsiec_pkg::CMD_LAST_ERR, 8'h12);
    // clean packet: failed flag drops, last code is kept
    pkt(15'h0000);
    rd_chk("err_ok", hsiec_pkg::CMD_LAST_ERR, 8'h02);
    tally_and_finish();
  end
endmodule // hsiec_cmd_test
